// file: hdl/torque_reference_generator.sv
// Torque reference source selection, analog processing and register file
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module torque_reference_generator (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Host inputs
    input wire logic AB_SELECT_IN,
    input wire logic TORQUE_DIR_IN,
    input wire logic signed [15:0] ANALOG_ONE_IN,
    input wire logic signed [15:0] ANALOG_TWO_IN,
    // Torque reference
    output logic signed [15:0] TORQUE_REF_OUT,
    output logic ROTATION_CW_OUT,
    output logic TORQUE_MODE_OUT
);
    localparam int W = tq_pkg::DATA_W;
    localparam int NCH = tq_pkg::NUM_CH;
    localparam logic signed [W-1:0] MAX_V = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W-1:0] MIN_V = {1'b1, {(W-1){1'b0}}};

    logic [15:0] ctrl_r;
    logic signed [W-1:0] comm_r;
    logic signed [W-1:0] sample_mon_r;
    logic signed [W-1:0] ref_r;
    logic signed [W-1:0] ref_nxt;
    logic rot_cw_r;
    logic rot_cw_nxt;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_data;
    logic req;
    logic wr_stb;
    logic torque_mode;
    tq_pkg::torque_src_type src;
    logic signed [W-1:0] analog_in [NCH];
    logic signed [W-1:0] filt_y [NCH];
    logic signed [W-1:0] chan_ref [NCH];
    logic signed [W-1:0] src_val [NCH];
    logic [NCH-1:0][15:0] chan_rd;
    logic signed [W:0] sum;
    logic signed [W-1:0] sel_val;

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] din,
                                               input logic [3:0] sel);
        lane_merge = {sel[1] ? din[15:8] : old[15:8], sel[0] ? din[7:0] : old[7:0]};
    endfunction

    assign req = WB_CYC_IN & WB_STB_IN;
    assign wr_stb = req & WB_WE_IN & ack_r;
    assign torque_mode = ctrl_r[tq_pkg::CTRL_MODE_LSB +: 4] == tq_pkg::MODE_TORQUE;
    assign src = tq_pkg::torque_src_type'(ctrl_r[tq_pkg::CTRL_SRC_LSB +: 3]);
    assign analog_in[0] = ANALOG_ONE_IN;
    assign analog_in[1] = ANALOG_TWO_IN;

    // Bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            dat_r <= '0;
        end else if (req && !ack_r) begin
            dat_r <= rd_data;
        end
    end

    assign WB_ACK_OUT = ack_r;
    assign WB_DAT_OUT = dat_r;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            ctrl_r <= tq_pkg::CTRL_RST;
        end else if (wr_stb && WB_ADR_IN == tq_pkg::OFS_CTRL) begin
            ctrl_r <= lane_merge(ctrl_r, WB_DAT_IN, WB_SEL_IN);
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            comm_r <= '0;
        end else if (wr_stb && WB_ADR_IN == tq_pkg::OFS_COMM) begin
            comm_r <= lane_merge(comm_r, WB_DAT_IN, WB_SEL_IN);
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            sample_mon_r <= '0;
        end else begin
            sample_mon_r <= ANALOG_ONE_IN;
        end
    end

    // Channel A and B share one structure with separate settings
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        localparam logic [7:0] BASE = (c == 0) ? tq_pkg::OFS_CHAN_A : tq_pkg::OFS_CHAN_B;
        logic signed [W-1:0] par [tq_pkg::NUM_PAR];
        logic [7:0] rel;
        logic hit;
        logic auto_adj;

        assign rel = WB_ADR_IN - BASE;
        assign hit = rel < 8'(4 * tq_pkg::NUM_PAR) && rel[1:0] == 2'b00;
        assign auto_adj = wr_stb && WB_ADR_IN == tq_pkg::OFS_AUTO_ADJ && WB_DAT_IN[c];
        assign chan_rd[c] = hit ? par[rel[4:2]] : 16'h0000;

        always_ff @(posedge CLK_SYS_IN) begin
            if (SRST_IN) begin
                for (int p = 0; p < tq_pkg::NUM_PAR; p++) begin
                    par[p] <= tq_pkg::PAR_RST[p];
                end
            end else if (auto_adj) begin
                par[tq_pkg::PAR_DRIFT] <= filt_y[c];
            end else if (wr_stb && hit) begin
                par[rel[4:2]] <= lane_merge(par[rel[4:2]], WB_DAT_IN, WB_SEL_IN);
            end
        end

        lowpass_filter #(
            .W(W),
            .SHIFT_W(tq_pkg::FILT_SHIFT_W),
            .FRAC_W(tq_pkg::FILT_FRAC_W)
        ) u_filt (
            .clk_in(CLK_SYS_IN),
            .srst_in(SRST_IN),
            .sample_in(analog_in[c]),
            .shift_in(par[tq_pkg::PAR_FILT][tq_pkg::FILT_SHIFT_W-1:0]),
            .filt_out(filt_y[c])
        );

        analog_path #(
            .W(W),
            .SPAN(tq_pkg::INPUT_SPAN_MV)
        ) u_path (
            .clk_in(CLK_SYS_IN),
            .srst_in(SRST_IN),
            .filt_in(filt_y[c]),
            .drift_in(par[tq_pkg::PAR_DRIFT]),
            .offset_in(par[tq_pkg::PAR_OFFSET]),
            .dead_in(par[tq_pkg::PAR_DEAD]),
            .full_in(par[tq_pkg::PAR_FULL]),
            .torque_out(chan_ref[c])
        );

        // Each channel runs from its digital setpoint or its analog path
        assign src_val[c] = ctrl_r[tq_pkg::CTRL_ANALOG_BIT + c] ? chan_ref[c] : par[tq_pkg::PAR_DIGIT];

        chk_auto_adjust: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
            auto_adj |=> par[tq_pkg::PAR_DRIFT] == $past(filt_y[c]))
            else $error("auto adjustment did not store the measured drift");
    end

    always_comb begin
        sum = $signed({src_val[0][W-1], src_val[0]}) + $signed({src_val[1][W-1], src_val[1]});
        unique case (src)
            tq_pkg::SRC_A: sel_val = src_val[0];
            tq_pkg::SRC_B: sel_val = src_val[1];
            tq_pkg::SRC_SUM: begin
                if (sum > $signed({MAX_V[W-1], MAX_V})) begin
                    sel_val = MAX_V;
                end else if (sum < $signed({MIN_V[W-1], MIN_V})) begin
                    sel_val = MIN_V;
                end else begin
                    sel_val = W'(sum);
                end
            end
            tq_pkg::SRC_SWITCH: sel_val = AB_SELECT_IN ? src_val[1] : src_val[0];
            tq_pkg::SRC_COMM: sel_val = comm_r;
            default: sel_val = '0;
        endcase
    end

    always_comb begin
        if (!torque_mode) begin
            ref_nxt = '0;
        end else if (TORQUE_DIR_IN) begin
            ref_nxt = (sel_val == MIN_V) ? MAX_V : -sel_val;
        end else begin
            ref_nxt = sel_val;
        end
        rot_cw_nxt = ctrl_r[tq_pkg::CTRL_ROT_BIT] ^ sel_val[W-1] ^ TORQUE_DIR_IN;
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            ref_r <= '0;
            rot_cw_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
            rot_cw_r <= rot_cw_nxt;
        end
    end

    assign TORQUE_REF_OUT = ref_r;
    assign ROTATION_CW_OUT = rot_cw_r;
    assign TORQUE_MODE_OUT = torque_mode;

    always_comb begin
        rd_data = '0;
        if (WB_ADR_IN == tq_pkg::OFS_CTRL) begin
            rd_data[15:0] = ctrl_r;
        end else if (WB_ADR_IN == tq_pkg::OFS_COMM) begin
            rd_data[15:0] = comm_r;
        end else if (WB_ADR_IN == tq_pkg::OFS_SAMPLE_MON) begin
            rd_data[15:0] = sample_mon_r;
        end else if (WB_ADR_IN == tq_pkg::OFS_TORQUE_MON) begin
            rd_data[15:0] = ref_r;
        end else if (WB_ADR_IN == tq_pkg::OFS_STATUS) begin
            rd_data[tq_pkg::STAT_MODE_BIT] = torque_mode;
            rd_data[tq_pkg::STAT_CW_BIT] = rot_cw_r;
        end else begin
            rd_data[15:0] = chan_rd[0] | chan_rd[1];
        end
    end

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (SRST_IN);

    sequence s_bus_req;
        req && !ack_r;
    endsequence

    sequence s_ack_pulse;
        ack_r ##1 !ack_r;
    endsequence

    sequence s_plain_torque;
        torque_mode && !TORQUE_DIR_IN;
    endsequence

    sequence s_read_req;
        req && !ack_r && !WB_WE_IN;
    endsequence

    chk_ack_timing: assert property (s_bus_req |=> s_ack_pulse)
        else $error("bus answer not a single pulse one cycle after request");
    chk_mode_gate: assert property (!torque_mode |=> ref_r == '0)
        else $error("reference not zero outside torque mode");
    chk_digital_src: assert property (s_plain_torque and src == tq_pkg::SRC_A
        && !ctrl_r[tq_pkg::CTRL_ANALOG_BIT] |=> ref_r == $past(g_chan[0].par[tq_pkg::PAR_DIGIT]))
        else $error("digital setpoint not used as reference");
    chk_ab_switch: assert property (s_plain_torque and src == tq_pkg::SRC_SWITCH
        |=> ref_r == ($past(AB_SELECT_IN) ? $past(src_val[1]) : $past(src_val[0])))
        else $error("select input did not pick source A or B");
    chk_comm_src: assert property (s_plain_torque and src == tq_pkg::SRC_COMM |=> ref_r == $past(comm_r))
        else $error("communication value not used as reference");
    chk_dir_invert: assert property (torque_mode && TORQUE_DIR_IN && sel_val != MIN_V
        |=> ref_r == -$past(sel_val))
        else $error("direction input did not invert the reference");
    chk_rotation_xor: assert property (1'b1 |=> rot_cw_r == ($past(ctrl_r[tq_pkg::CTRL_ROT_BIT])
        ^ $past(sel_val[W-1]) ^ $past(TORQUE_DIR_IN)))
        else $error("rotation direction not the xor of its three terms");
    chk_ref_monitor: assert property (s_bus_req and WB_ADR_IN == tq_pkg::OFS_TORQUE_MON
        |=> WB_DAT_OUT[15:0] == $past(ref_r) && WB_ACK_OUT)
        else $error("torque monitor read did not return the reference");
    chk_sample_monitor: assert property (s_read_req and WB_ADR_IN == tq_pkg::OFS_SAMPLE_MON
        |=> WB_DAT_OUT[15:0] == $past(ANALOG_ONE_IN, 2))
        else $error("sample monitor read did not return the registered sample");
    chk_status_read: assert property (s_read_req and WB_ADR_IN == tq_pkg::OFS_STATUS
        |=> WB_DAT_OUT == {30'h00000000, $past(rot_cw_r), $past(torque_mode)})
        else $error("status read did not show mode and rotation");
    chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("bus answer stood for more than one cycle");
    chk_ctrl_write: assert property (wr_stb && WB_ADR_IN == tq_pkg::OFS_CTRL && WB_SEL_IN[1:0] == 2'h3
        |=> ctrl_r == $past(WB_DAT_IN[15:0]))
        else $error("control write did not land");
    chk_comm_lanes: assert property (wr_stb && WB_ADR_IN == tq_pkg::OFS_COMM && !WB_SEL_IN[0]
        |=> comm_r[7:0] == $past(comm_r[7:0]))
        else $error("unselected byte lane of the communication value changed");

    // Source and direction checks beyond the basic ones
    chk_analog_select: assert property (s_plain_torque and src == tq_pkg::SRC_A
        && ctrl_r[tq_pkg::CTRL_ANALOG_BIT] |=> ref_r == $past(chan_ref[0]))
        else $error("analog path of source A not used as reference");
    chk_b_source: assert property (s_plain_torque and src == tq_pkg::SRC_B
        |=> ref_r == $past(src_val[1]))
        else $error("source B not used as reference");
    chk_sum_source: assert property (s_plain_torque and src == tq_pkg::SRC_SUM && sum[W] == sum[W-1]
        |=> ref_r == $past(src_val[0]) + $past(src_val[1]))
        else $error("sum of sources A and B not used as reference");
    chk_idle_source: assert property (torque_mode && ctrl_r[tq_pkg::CTRL_SRC_LSB +: 3] > 3'h4
        |=> ref_r == '0)
        else $error("unused source code did not give zero");
    chk_min_invert: assert property (torque_mode && TORQUE_DIR_IN && sel_val == MIN_V
        |=> ref_r == MAX_V)
        else $error("inverting the most negative value did not saturate");
endmodule

// file: hdl/tq_pkg.sv
// Constants and types shared by the torque reference generator
package tq_pkg;
    localparam int DATA_W = 16;
    localparam int ADR_W = 8;
    localparam int NUM_CH = 2;
    localparam int NUM_PAR = 6;
    localparam int FILT_SHIFT_W = 4;
    localparam int FILT_FRAC_W = 15;
    localparam int INPUT_SPAN_MV = 10000;
    localparam logic [3:0] MODE_TORQUE = 4'h2;

    typedef enum logic [2:0] {
        SRC_A = 3'b000,
        SRC_B = 3'b001,
        SRC_SUM = 3'b010,
        SRC_SWITCH = 3'b011,
        SRC_COMM = 3'b100
    } torque_src_type;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COMM = 8'h08;
    localparam logic [7:0] OFS_CHAN_A = 8'h10;
    localparam logic [7:0] OFS_CHAN_B = 8'h30;
    localparam logic [7:0] OFS_AUTO_ADJ = 8'h50;
    localparam logic [7:0] OFS_SAMPLE_MON = 8'h60;
    localparam logic [7:0] OFS_TORQUE_MON = 8'h64;
    localparam logic [7:0] OFS_STATUS = 8'h68;

    // Word index of each parameter inside a channel block
    localparam int PAR_FILT = 0;
    localparam int PAR_DRIFT = 1;
    localparam int PAR_OFFSET = 2;
    localparam int PAR_DEAD = 3;
    localparam int PAR_FULL = 4;
    localparam int PAR_DIGIT = 5;
    localparam logic [15:0] PAR_RST [NUM_PAR] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03e8, 16'h0000};

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ROT_BIT = 4;
    localparam int CTRL_ANALOG_BIT = 5;
    localparam int CTRL_SRC_LSB = 8;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // Status register fields
    localparam int STAT_MODE_BIT = 0;
    localparam int STAT_CW_BIT = 1;
endpackage

// file: hdl/lowpass_filter.sv
// First-order low-pass filter on one analog sample stream
`timescale 1ns/1ps
module lowpass_filter #(
    parameter int W = 16,
    parameter int SHIFT_W = 4,
    parameter int FRAC_W = 15
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Sample and time constant
    input wire logic signed [W-1:0] sample_in,
    input wire logic [SHIFT_W-1:0] shift_in,
    // Filtered sample
    output logic signed [W-1:0] filt_out
);
    localparam int AW = W + FRAC_W;
    logic signed [AW-1:0] acc_r;
    logic signed [AW-1:0] acc_nxt;
    logic signed [AW-1:0] target;
    logic signed [AW:0] diff;

    always_comb begin
        target = $signed({sample_in, {FRAC_W{1'b0}}});
        diff = $signed({target[AW-1], target}) - $signed({acc_r[AW-1], acc_r});
        if (shift_in == '0) begin
            acc_nxt = target;
        end else begin
            acc_nxt = acc_r + AW'(diff >>> shift_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign filt_out = acc_r[AW-1:FRAC_W];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    chk_filt_bypass: assert property (shift_in == '0 |=> filt_out == $past(sample_in))
        else $error("filter with zero constant did not pass the sample");
    chk_filt_settle: assert property ((shift_in == SHIFT_W'(1) && $stable(sample_in))[*8] |->
        (filt_out - sample_in <= 1) && (sample_in - filt_out <= 1) || !$stable(filt_out))
        else $error("filter did not move toward a steady sample");
endmodule

// file: hdl/analog_path.sv
// Drift, offset, dead zone and full-scale stage of one analog channel
`timescale 1ns/1ps
module analog_path #(
    parameter int W = 16,
    parameter int SPAN = 10000
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Filtered sample and channel settings
    input wire logic signed [W-1:0] filt_in,
    input wire logic signed [W-1:0] drift_in,
    input wire logic signed [W-1:0] offset_in,
    input wire logic signed [W-1:0] dead_in,
    input wire logic signed [W-1:0] full_in,
    // Torque reference of this channel
    output logic signed [W-1:0] torque_out
);
    localparam logic signed [31:0] SPAN_V = 32'(SPAN);
    localparam logic signed [47:0] MAX_V = 48'((1 << (W - 1)) - 1);
    logic signed [31:0] y3;
    logic signed [31:0] y3c;
    logic signed [31:0] y4;
    logic signed [31:0] y5;
    logic signed [31:0] mag;
    logic signed [47:0] prod;
    logic signed [47:0] quo;
    logic signed [W-1:0] torque_nxt;
    logic in_dead;

    always_comb begin
        y3 = 32'(filt_in) - 32'(drift_in);
        if (y3 > SPAN_V) begin
            y3c = SPAN_V;
        end else if (y3 < -SPAN_V) begin
            y3c = -SPAN_V;
        end else begin
            y3c = y3;
        end
        y4 = y3c - 32'(offset_in);
        mag = (y4 < 0) ? -y4 : y4;
        in_dead = mag <= 32'(dead_in);
        y5 = in_dead ? 32'sh0 : y4;
        prod = 48'(y5) * 48'(full_in);
        quo = prod / 48'(SPAN_V);
        if (quo > MAX_V) begin
            torque_nxt = W'(MAX_V);
        end else if (quo < -MAX_V) begin
            torque_nxt = W'(-MAX_V);
        end else begin
            torque_nxt = W'(quo);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            torque_out <= '0;
        end else begin
            torque_out <= torque_nxt;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    chk_dead_zero: assert property (in_dead |=> torque_out == '0)
        else $error("value inside dead zone was not forced to zero");
    chk_full_scale: assert property (y5 == SPAN_V |=> torque_out == $past(full_in))
        else $error("full input span did not give the full-scale value");
    chk_offset_zero: assert property (y3 == 32'(offset_in) && y3 <= SPAN_V && y3 >= -SPAN_V
        |=> torque_out == '0)
        else $error("input equal to offset did not give zero");
endmodule

// file: dv/host_model.sv
// Host controller model driving the select, direction and analog inputs
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clk_in,
    // Levels wanted by the bench
    input wire logic ab_want_in,
    input wire logic dir_want_in,
    input wire logic signed [15:0] one_want_in,
    input wire logic signed [15:0] two_want_in,
    // Levels at the device inputs
    output logic ab_select_out = 1'b0,
    output logic torque_dir_out = 1'b0,
    output logic signed [15:0] analog_one_out = 16'sh0000,
    output logic signed [15:0] analog_two_out = 16'sh0000
);
    // Host changes its outputs only right after a rising edge
    always @(posedge clk_in) begin
        ab_select_out <= ab_want_in;
        torque_dir_out <= dir_want_in;
    end

    // Analog sources are always driven, never released
    always @(posedge clk_in) begin
        analog_one_out <= one_want_in;
        analog_two_out <= two_want_in;
    end
endmodule

// file: dv/tb.sv
// Self-checking bench for the torque reference generator
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h00000000;
    logic [31:0] dat_r;
    logic ack;
    logic ab_want = 1'b0;
    logic dir_want = 1'b0;
    logic signed [15:0] one_want = 16'sh0000;
    logic signed [15:0] two_want = 16'sh0000;
    logic ab_pin;
    logic dir_pin;
    logic signed [15:0] one_pin;
    logic signed [15:0] two_pin;
    logic signed [15:0] tref;
    logic rot_cw;
    logic tmode;
    logic [15:0] rd;
    int fail_count = 0;
    int checks_done = 0;
    logic [15:0] src_exp [8] = '{16'h007b, 16'h004d, 16'h00c8, 16'h007b, 16'hfe0c, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] an_x [7] = '{16'h1388, 16'h1518, 16'h0fa0, 16'h12c0, 16'h12c1, 16'h0c7f, 16'h2ee0};
    logic [15:0] an_d [7] = '{16'h0000, 16'h0190, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] an_o [7] = '{16'h0000, 16'h0000, 16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h0000};
    logic [15:0] an_z [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0320, 16'h0320, 16'h0320, 16'h0000};
    logic [15:0] an_e [7] = '{16'h1388, 16'h1388, 16'h0000, 16'h0000, 16'h0321, 16'hfcdf, 16'h2710};

    always #2 clk = ~clk;

    host_model host_model_inst (
        .clk_in(clk), .ab_want_in(ab_want), .dir_want_in(dir_want), .one_want_in(one_want),
        .two_want_in(two_want), .ab_select_out(ab_pin), .torque_dir_out(dir_pin),
        .analog_one_out(one_pin), .analog_two_out(two_pin)
    );

    torque_reference_generator torque_reference_generator_inst (
        .CLK_SYS_IN(clk), .SRST_IN(srst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack),
        .AB_SELECT_IN(ab_pin), .TORQUE_DIR_IN(dir_pin), .ANALOG_ONE_IN(one_pin),
        .ANALOG_TWO_IN(two_pin), .TORQUE_REF_OUT(tref), .ROTATION_CW_OUT(rot_cw),
        .TORQUE_MODE_OUT(tmode)
    );

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [15:0] d,
                            output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_w <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 30);
        q = dat_r[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            $display("BAD wb_ack expected 1 seen %b", ack);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb_cycle(1'b1, a, 4'h3, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        wb_cycle(1'b0, a, 4'h3, 16'h0000, q);
        check16("register", exp, q);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [15:0] ctrl(input logic [3:0] m, input logic r, input logic aa, input logic ab,
                                         input logic [2:0] s);
        return {5'h00, s, 1'b0, ab, aa, r, m};
    endfunction

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        settle(2);
        check16("tref_rst", 16'h0000, tref);
        check1("mode_rst", 1'b0, tmode);
        rd_check(8'h00, 16'h0000);
        rd_check(8'h20, 16'h03e8);
        rd_check(8'h40, 16'h03e8);
        wr(8'h04, 16'h5555);
        rd_check(8'h04, 16'h0000);
        rd_check(8'h50, 16'h0000);
        wr(8'h08, 16'h1234);
        wb_cycle(1'b1, 8'h08, 4'h2, 16'hab00, rd);
        rd_check(8'h08, 16'hab34);
        // Every source code with digital setpoints and a communication value
        wr(8'h24, 16'h007b);
        wr(8'h44, 16'h004d);
        wr(8'h08, 16'hfe0c);
        for (int s = 0; s < 8; s++) begin
            wr(8'h00, ctrl(4'h2, 1'b0, 1'b0, 1'b0, s[2:0]));
            settle(3);
            check16("src_ref", src_exp[s], tref);
            check1("mode_on", 1'b1, tmode);
        end
        wr(8'h00, ctrl(4'h2, 1'b0, 1'b0, 1'b0, 3'h3));
        ab_want = 1'b1;
        settle(3);
        check16("ab_on", 16'h004d, tref);
        ab_want = 1'b0;
        settle(3);
        check16("ab_off", 16'h007b, tref);
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, ctrl(m[3:0], 1'b0, 1'b0, 1'b0, 3'h4));
            settle(3);
            check16("mode_ref", (m == 2) ? 16'hfe0c : 16'h0000, tref);
            check1("mode_flag", m == 2, tmode);
        end
        // Direction setting, sign and direction input in all combinations
        for (int k = 0; k < 8; k++) begin
            wr(8'h08, k[1] ? 16'hff9c : 16'h0064);
            wr(8'h00, ctrl(4'h2, k[2], 1'b0, 1'b0, 3'h4));
            dir_want = k[0];
            settle(4);
            check16("dir_ref", (k[1] ^ k[0]) ? 16'hff9c : 16'h0064, tref);
            check1("rot_cw", k[2] ^ k[1] ^ k[0], rot_cw);
        end
        rd_check(8'h68, 16'h0003);
        wr(8'h08, 16'h8000);
        settle(4);
        check16("dir_min", 16'h7fff, tref);
        dir_want = 1'b0;
        // Analog chain with unit full scale so the result is the corrected voltage
        wr(8'h00, ctrl(4'h2, 1'b0, 1'b1, 1'b1, 3'h0));
        wr(8'h20, 16'h2710);
        for (int i = 0; i < 7; i++) begin
            wr(8'h14, an_d[i]);
            wr(8'h18, an_o[i]);
            wr(8'h1c, an_z[i]);
            one_want = an_x[i];
            settle(5);
            check16("analog_ref", an_e[i], tref);
        end
        rd_check(8'h60, 16'h2ee0);
        rd_check(8'h64, 16'h2710);
        wr(8'h20, 16'h03e8);
        one_want = 16'sh1388;
        settle(5);
        check16("scaled_ref", 16'h01f4, tref);
        one_want = 16'sh012c;
        settle(5);
        wr(8'h50, 16'h0001);
        rd_check(8'h14, 16'h012c);
        settle(3);
        check16("adjusted_ref", 16'h0000, tref);
        // Step response through a slow filter
        wr(8'h14, 16'h0000);
        wr(8'h20, 16'h2710);
        one_want = 16'sh0000;
        wr(8'h10, 16'h0001);
        settle(60);
        one_want = 16'sh0fa0;
        settle(4);
        check1("filt_slow", 1'b1, tref > 16'sh0000 && tref < 16'sh0fa0);
        settle(200);
        check1("filt_final", 1'b1, tref >= 16'sh0f96 && tref <= 16'sh0fa0);
        // Channel B on its own input and reset parameters
        wr(8'h00, ctrl(4'h2, 1'b0, 1'b1, 1'b1, 3'h1));
        two_want = 16'sh1388;
        settle(5);
        check16("chan_b_ref", 16'h01f4, tref);
        wr(8'h50, 16'h0002);
        rd_check(8'h34, 16'h1388);
        stop_test();
    end
endmodule
